// ### shared/fsr_params.svh
// fsr_params.svh: opcodes, bit positions, reset values and timing counts
// of the first flash status byte and its command logic.
// assumes: included by bare name, after `timescale in the including file.
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// ----------------------------------------------------------------------
// serial opcodes
// ----------------------------------------------------------------------
`define FSR_OPC_REG_WRITE    8'h01
`define FSR_OPC_PROGRAM      8'h02
`define FSR_OPC_WPL_CLEAR    8'h04
`define FSR_OPC_STAT_READ    8'h05
`define FSR_OPC_WPL_SET      8'h06
`define FSR_OPC_STAT2_READ   8'h07
`define FSR_OPC_STAT_CLEAR   8'h30
`define FSR_OPC_BULK_ERASE   8'h60
`define FSR_OPC_ERASE_PAUSE  8'h75
`define FSR_OPC_ERASE_RESUME 8'h7A
`define FSR_OPC_PROG_PAUSE   8'h85
`define FSR_OPC_PROG_RESUME  8'h8A
`define FSR_OPC_SECT_ERASE   8'hD8
`define FSR_OPC_SW_RESET     8'hF0

// ----------------------------------------------------------------------
// status byte layout and reset values
// ----------------------------------------------------------------------
`define FSR_BIT_LOCK     7
`define FSR_BIT_PFAIL    6
`define FSR_BIT_EFAIL    5
`define FSR_GUARD_HI     4
`define FSR_GUARD_LO     2
`define FSR_BIT_WPL      1
`define FSR_BIT_BUSY     0
`define FSR_GUARD_VOL_RST 3'h7
`define FSR_GUARD_NV_RST  3'h0
`define FSR_GUARD_NONE    3'h0
`define FSR_LOCK_RST      1'h0
`define FSR_STAT2_VALUE   8'h00

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSR_CLK_PERIOD_NS   10
`define FSR_VOL_WRITE_NS    50
`define FSR_VOL_WRITE_CYC \
   ((`FSR_VOL_WRITE_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)
`define FSR_TIMER_W         24

`endif

// ### shared/fsr_pkg.sv
// fsr_pkg: types shared by the status byte logic.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none
package fsr_pkg;
   // serial frame position, gray coded along idle -> opcode -> data
   typedef enum logic [1:0] {
      FSR_FR_IDLE   = 2'b00,
      FSR_FR_OPCODE = 2'b01,
      FSR_FR_DATA   = 2'b11
   } fsr_frame_t;

   // kind of operation that holds the device busy
   typedef enum logic [2:0] {
      FSR_OP_NONE  = 3'b000,
      FSR_OP_REG   = 3'b001,
      FSR_OP_PROG  = 3'b011,
      FSR_OP_ERASE = 3'b010,
      FSR_OP_BULK  = 3'b110
   } fsr_op_t;
endpackage : fsr_pkg
`default_nettype wire

// ### design/fsr_sync.sv
// fsr_sync: two flip-flop synchroniser for a group of pin levels.
// assumes: each bit is an independent level; no bus coherency is needed.
`timescale 1ns/100ps
`default_nettype none
module fsr_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end
endmodule : fsr_sync
`default_nettype wire

// ### design/fsr_op_timer.sv
// fsr_op_timer: counts out the duration of a busy operation.
// assumes: start, hold and abort are pulses or levels on clock_i.
`timescale 1ns/100ps
`default_nettype none
module fsr_op_timer #(
   parameter int unsigned W = 24
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [W-1:0] load_i,
   input wire logic hold_i,
   input wire logic abort_i,
   output logic done_o
);
   logic [W-1:0] cnt_reg;
   logic run_reg;

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            run_reg <= 1'b0;
            cnt_reg <= '0;
         end else if (start_i) begin
            run_reg <= 1'b1;
            cnt_reg <= load_i;
         end else if (run_reg && !hold_i) begin
            if (cnt_reg <= W'(1)) begin
               run_reg <= 1'b0;
               done_o <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - W'(1);
            end
         end
      end
   end
endmodule : fsr_op_timer
`default_nettype wire

// ### design/fsr_status_reg.sv
// fsr_status_reg: first status byte of a serial flash and its commands.
// assumes: serial mode 0 host, sck far slower than clock_i; protected
// range decode and the array itself sit outside and answer on clock_i.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_params.svh"

// What this block does
// - status byte read with 05h, written with 01h over the serial pins
// - lock bit set and protect pin low: register writes ignored
// - protect pin high: register write may change lock and guard bits
// - lock bit clear: protect pin has no effect on register writes
// - program fail flag set on failure or program into protected area
// - erase fail flag set on failure or erase of a guarded sector
// - whole array erase never flags guarded sectors as erase failure
// - fail flags read only, cleared only by status clear 30h, software reset F0h or hardware reset
// - guard bits volatile when volatility select is 1, else non-volatile
// - any guard bit set: program and erase of guarded region refused
// - whole array erase runs only when all guard bits are zero
// - write permit latch must be set for write, program or erase
// - 06h sets latch, 04h clears it, completed register write also clears it
// - latch cleared when program, write or erase completes successfully
// - latch zero after power up, hardware reset or software reset
// - busy flag high while an operation runs, new operations ignored
// - while busy only reads, pauses, resumes, status clear and reset accepted
// - a fail flag keeps busy high until status clear
// - guard bits ignore register writes while the freeze input is high
module fsr_status_reg #(
   parameter int unsigned NV_WRITE_CYCLES = 20000,
   parameter int unsigned PROG_CYCLES = 30000,
   parameter int unsigned ERASE_CYCLES = 50000,
   parameter int unsigned BULK_CYCLES = 100000
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic write_guard_n_i,
   input wire logic guard_volatile_i,
   input wire logic guard_freeze_i,
   input wire logic target_guarded_i,
   input wire logic otp_locked_i,
   input wire logic array_fail_i,
   output logic so_o,
   output logic so_oe_o,
   output logic [7:0] status_byte_one_o,
   output fsr_pkg::fsr_op_t op_kind_o,
   output logic program_start_o,
   output logic erase_start_o,
   output logic bulk_start_o
);
   import fsr_pkg::*;

   function automatic logic is_cmd(input logic [7:0] opc,
                                   input logic [7:0] code);
      is_cmd = (opc == code);
   endfunction : is_cmd

   // -------------------------------------------------------------------
   // pin synchronisers and edge detection
   // -------------------------------------------------------------------
   logic sck_s, cs_n_s, si_s, wp_n_s;
   logic sck_d_reg, cs_act_d_reg;
   logic sck_rise, sck_fall, cs_act, frame_start, frame_stop;

   fsr_sync #(.W(4), .RST_VAL(4'h6)) u_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i({sck_i, cs_n_i, write_guard_n_i, si_i}),
      .sync_o({sck_s, cs_n_s, wp_n_s, si_s})
   );

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sck_d_reg <= 1'b0;
         cs_act_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= sck_s;
         cs_act_d_reg <= ~cs_n_s;
      end
   end

   assign cs_act = ~cs_n_s;
   assign sck_rise = cs_act & sck_s & ~sck_d_reg;
   assign sck_fall = cs_act & ~sck_s & sck_d_reg;
   assign frame_start = cs_act & ~cs_act_d_reg;
   assign frame_stop = ~cs_act & cs_act_d_reg;

   // -------------------------------------------------------------------
   // serial frame: opcode byte then data bytes
   // -------------------------------------------------------------------
   fsr_frame_t frame_reg;
   logic [2:0] bit_cnt_reg;
   logic [7:0] rx_reg, opcode_reg, data_reg;
   logic data_seen_reg;
   logic [7:0] rx_next;
   logic byte_done;

   assign rx_next = {rx_reg[6:0], si_s};
   assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         frame_reg <= FSR_FR_IDLE;
         bit_cnt_reg <= 3'h0;
         rx_reg <= 8'h00;
         opcode_reg <= 8'h00;
         data_reg <= 8'h00;
         data_seen_reg <= 1'b0;
      end else if (frame_start) begin
         frame_reg <= FSR_FR_OPCODE;
         bit_cnt_reg <= 3'h0;
         data_seen_reg <= 1'b0;
      end else if (frame_stop) begin
         frame_reg <= FSR_FR_IDLE;
      end else if (sck_rise) begin
         rx_reg <= rx_next;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (byte_done) begin
            case (frame_reg)
               FSR_FR_OPCODE: begin
                  opcode_reg <= rx_next;
                  frame_reg <= FSR_FR_DATA;
               end
               FSR_FR_DATA: begin
                  if (!data_seen_reg) begin
                     data_reg <= rx_next;
                  end
                  data_seen_reg <= 1'b1;
               end
               default: frame_reg <= FSR_FR_IDLE;
            endcase
         end
      end
   end

   // commands act when chip select rises on a byte boundary
   logic exec;
   assign exec = frame_stop && (frame_reg == FSR_FR_DATA) &&
                 (bit_cnt_reg == 3'h0);

   // -------------------------------------------------------------------
   // command decode
   // -------------------------------------------------------------------
   fsr_op_t op_reg;
   logic busy_reg, paused_reg, wpl_reg, perr_reg, eerr_reg, lock_reg;
   logic [2:0] guard_vol_reg, guard_nv_reg, guard_now;
   logic ready, hw_locked, op_done, fail_done, p_set, e_set;
   logic do_reg_write, do_prog, do_sect, do_bulk, do_pause, do_resume;
   logic do_clr, do_swrst, do_wpset, do_wpclr, op_start;
   logic [`FSR_TIMER_W-1:0] op_load;
   fsr_op_t op_start_kind;

   assign guard_now = guard_volatile_i ? guard_vol_reg : guard_nv_reg;
   assign hw_locked = lock_reg & ~wp_n_s;
   assign ready = ~busy_reg;

   assign do_reg_write = exec && is_cmd(opcode_reg, `FSR_OPC_REG_WRITE) &&
                   data_seen_reg && ready && wpl_reg && !hw_locked;
   assign do_prog = exec && is_cmd(opcode_reg, `FSR_OPC_PROGRAM) &&
                    ready && wpl_reg;
   assign do_sect = exec && is_cmd(opcode_reg, `FSR_OPC_SECT_ERASE) &&
                    ready && wpl_reg;
   assign do_bulk = exec && is_cmd(opcode_reg, `FSR_OPC_BULK_ERASE) &&
                    ready && wpl_reg &&
                    (guard_now == `FSR_GUARD_NONE);
   assign do_pause = exec && !paused_reg &&
      ((is_cmd(opcode_reg, `FSR_OPC_ERASE_PAUSE) &&
        (op_reg == FSR_OP_ERASE || op_reg == FSR_OP_BULK)) ||
       (is_cmd(opcode_reg, `FSR_OPC_PROG_PAUSE) &&
        op_reg == FSR_OP_PROG));
   assign do_resume = exec && paused_reg &&
      (is_cmd(opcode_reg, `FSR_OPC_ERASE_RESUME) ||
       is_cmd(opcode_reg, `FSR_OPC_PROG_RESUME));
   assign do_clr = exec && is_cmd(opcode_reg, `FSR_OPC_STAT_CLEAR);
   assign do_swrst = exec && is_cmd(opcode_reg, `FSR_OPC_SW_RESET);
   assign do_wpset = exec && is_cmd(opcode_reg, `FSR_OPC_WPL_SET) && ready;
   assign do_wpclr = exec && is_cmd(opcode_reg, `FSR_OPC_WPL_CLEAR) &&
                     ready;

   // guarded or OTP-locked program targets and guarded sector erase targets fail at once instead of starting the array
   assign op_start = do_reg_write ||
                     (do_prog && !(target_guarded_i || otp_locked_i)) ||
                     (do_sect && !target_guarded_i) || do_bulk;
   assign fail_done = op_done && (op_reg != FSR_OP_REG) && array_fail_i;

   always_comb begin
      op_start_kind = FSR_OP_REG;
      op_load = `FSR_TIMER_W'(NV_WRITE_CYCLES);
      if (do_prog) begin
         op_start_kind = FSR_OP_PROG;
         op_load = `FSR_TIMER_W'(PROG_CYCLES);
      end else if (do_sect) begin
         op_start_kind = FSR_OP_ERASE;
         op_load = `FSR_TIMER_W'(ERASE_CYCLES);
      end else if (do_bulk) begin
         op_start_kind = FSR_OP_BULK;
         op_load = `FSR_TIMER_W'(BULK_CYCLES);
      end else if (guard_volatile_i &&
                   data_reg[`FSR_BIT_LOCK] == lock_reg) begin
         op_load = `FSR_TIMER_W'(`FSR_VOL_WRITE_CYC);
      end
   end

   fsr_op_timer #(.W(`FSR_TIMER_W)) u_timer (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .start_i(op_start),
      .load_i(op_load),
      .hold_i(paused_reg),
      .abort_i(do_swrst),
      .done_o(op_done)
   );

   // -------------------------------------------------------------------
   // busy flag and operation kind
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy_reg <= 1'b0;
         op_reg <= FSR_OP_NONE;
         paused_reg <= 1'b0;
      end else if (do_swrst) begin
         busy_reg <= 1'b0;
         op_reg <= FSR_OP_NONE;
         paused_reg <= 1'b0;
      end else begin
         if (op_start) begin
            busy_reg <= 1'b1;
            op_reg <= op_start_kind;
         end else if (p_set || e_set) begin
            busy_reg <= 1'b1;
         end else if (op_done) begin
            busy_reg <= 1'b0;
         end else if (do_clr && (perr_reg || eerr_reg) &&
                      op_reg == FSR_OP_NONE) begin
            busy_reg <= 1'b0;
         end
         if (op_done) begin
            op_reg <= FSR_OP_NONE;
         end
         if (do_pause) begin
            paused_reg <= 1'b1;
         end else if (do_resume) begin
            paused_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // error flags
   // -------------------------------------------------------------------
   assign p_set = (do_prog && (target_guarded_i || otp_locked_i)) ||
                  (fail_done && op_reg == FSR_OP_PROG);
   assign e_set = (do_sect && target_guarded_i) ||
                  (fail_done && op_reg != FSR_OP_PROG);

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         perr_reg <= 1'b0;
         eerr_reg <= 1'b0;
      end else begin
         if (p_set) begin
            perr_reg <= 1'b1;
         end else if (do_clr || do_swrst) begin
            perr_reg <= 1'b0;
         end
         if (e_set) begin
            eerr_reg <= 1'b1;
         end else if (do_clr || do_swrst) begin
            eerr_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // write permit latch
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wpl_reg <= 1'b0;
      end else if (do_swrst) begin
         wpl_reg <= 1'b0;
      end else if (op_done && !fail_done) begin
         wpl_reg <= 1'b0;
      end else if (do_wpset) begin
         wpl_reg <= 1'b1;
      end else if (do_wpclr) begin
         wpl_reg <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // lock bit and guard bits
   // -------------------------------------------------------------------
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lock_reg <= `FSR_LOCK_RST;
         guard_nv_reg <= `FSR_GUARD_NV_RST;
         guard_vol_reg <= `FSR_GUARD_VOL_RST;
      end else if (do_swrst) begin
         guard_vol_reg <= `FSR_GUARD_VOL_RST;
      end else if (do_reg_write) begin
         lock_reg <= data_reg[`FSR_BIT_LOCK];
         if (!guard_freeze_i) begin
            if (guard_volatile_i) begin
               guard_vol_reg <= data_reg[`FSR_GUARD_HI:`FSR_GUARD_LO];
            end else begin
               guard_nv_reg <= data_reg[`FSR_GUARD_HI:`FSR_GUARD_LO];
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // status view, serial output and array strobes
   // -------------------------------------------------------------------
   logic [7:0] status_now, tx_reg;
   logic reading_reg;

   assign status_now = {lock_reg, perr_reg, eerr_reg, guard_now, wpl_reg,
                        busy_reg & ~paused_reg};

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_reg <= 8'h00;
         reading_reg <= 1'b0;
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
      end else begin
         so_oe_o <= cs_act && reading_reg;
         if (frame_start) begin
            reading_reg <= 1'b0;
         end else if (byte_done) begin
            if (frame_reg == FSR_FR_OPCODE) begin
               reading_reg <= is_cmd(rx_next, `FSR_OPC_STAT_READ) ||
                              is_cmd(rx_next, `FSR_OPC_STAT2_READ);
            end
            // the status byte repeats for as long as the host clocks
            if (is_cmd(frame_reg == FSR_FR_OPCODE ? rx_next : opcode_reg,
                       `FSR_OPC_STAT_READ)) begin
               tx_reg <= status_now;
            end else begin
               tx_reg <= `FSR_STAT2_VALUE;
            end
         end else if (sck_fall && reading_reg) begin
            so_o <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_byte_one_o <= 8'h00;
         op_kind_o <= FSR_OP_NONE;
         program_start_o <= 1'b0;
         erase_start_o <= 1'b0;
         bulk_start_o <= 1'b0;
      end else begin
         status_byte_one_o <= status_now;
         op_kind_o <= op_reg;
         program_start_o <= op_start && do_prog;
         erase_start_o <= op_start && do_sect;
         bulk_start_o <= do_bulk;
      end
   end

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_write_cmd;
      exec && is_cmd(opcode_reg, `FSR_OPC_REG_WRITE) && data_seen_reg;
   endsequence
   sequence s_hold_guard;
      $stable(lock_reg) && $stable(guard_nv_reg) && $stable(guard_vol_reg);
   endsequence

   a_hw_lock_hold: assert property (
      s_write_cmd and (hw_locked && !do_swrst) |=> s_hold_guard)
      else $error("register write changed bits in protected mode");
   a_write_lock_bit: assert property (
      s_write_cmd and (ready && wpl_reg && !lock_reg)
      |=> lock_reg == $past(data_reg[`FSR_BIT_LOCK]))
      else $error("register write did not take the lock bit");
   a_clear_flags: assert property (
      do_clr && !p_set && !e_set |=> !perr_reg && !eerr_reg)
      else $error("status clear left a fail flag set");
   a_bulk_guarded: assert property (
      exec && is_cmd(opcode_reg, `FSR_OPC_BULK_ERASE) &&
      guard_now != `FSR_GUARD_NONE |=> !bulk_start_o ##1 !busy_reg[*2]
      or $past(busy_reg, 1))
      else $error("whole array erase ran with guard bits set");
   a_wpl_set_cmd: assert property (
      exec && is_cmd(opcode_reg, `FSR_OPC_WPL_SET) && ready
      |=> wpl_reg ##1 wpl_reg)
      else $error("write permit set did not take");
   a_wpl_done: assert property (
      op_done && !fail_done && !do_swrst |=> !wpl_reg && !busy_reg)
      else $error("latch or busy left set after successful operation");
   a_err_busy: assert property (
      perr_reg || eerr_reg |-> busy_reg)
      else $error("fail flag set while busy is low");
   a_prog_needs_wpl: assert property (
      exec && is_cmd(opcode_reg, `FSR_OPC_PROGRAM) && ready && !wpl_reg
      |=> (!program_start_o && !busy_reg && !perr_reg)[*2])
      else $error("program started without write permit");
   a_busy_refuse: assert property (
      busy_reg && exec && is_cmd(opcode_reg, `FSR_OPC_WPL_CLEAR) &&
      wpl_reg && !op_done |=> wpl_reg)
      else $error("write permit clear accepted while busy");
endmodule : fsr_status_reg
`default_nettype wire

// ### tb/fsr_host_model.sv
// fsr_host_model: serial host that issues one flash command per frame.
// assumes: clock_i is the bench clock; sck runs only inside frames.
`timescale 1ns/100ps
`default_nettype none
module fsr_host_model (
   input wire logic clock_i,
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // --------------------------------------------------------------
   // frame: opcode, then nb-1 copies of dat; rd is last byte seen
   // --------------------------------------------------------------
   task automatic xfer(input logic [7:0] op, input logic [7:0] dat,
         input int nb, output logic [7:0] rd);
      logic [7:0] sh;
      rd = 8'h00;
      @(posedge clock_i) cs_n_o <= 1'b0;
      for (int b = 0; b < nb; b++) begin
         sh = (b == 0) ? op : dat;
         // msb first, data set while sck low
         for (int i = 7; i >= 0; i--) begin
            si_o <= sh[i];
            repeat (6) @(posedge clock_i);
            sck_o <= 1'b1;
            rd = {rd[6:0], (so_oe_i === 1'b1) ? so_i : 1'bx};
            // 60/70 ns high halves after a 60 ns low half average a 125 ns period
            repeat (6 + (i & 1)) @(posedge clock_i);
            sck_o <= 1'b0;
         end
      end
      repeat (6) @(posedge clock_i);
      cs_n_o <= 1'b1;
      // released data line shows the inverse of its last bit
      si_o <= ~sh[0];
      repeat (13) @(posedge clock_i);
   endtask : xfer
endmodule : fsr_host_model
`default_nettype wire

// ### tb/fsr_status_reg_tb_top.sv
// fsr_status_reg_tb_top: command sequences against the status byte.
// assumes: fsr_host_model drives the serial pins; short op counts.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_params.svh"
module fsr_status_reg_tb_top;
   import fsr_pkg::*;
   localparam logic [7:0] WS = `FSR_OPC_WPL_SET;
   localparam logic [7:0] WC = `FSR_OPC_WPL_CLEAR;
   localparam logic [7:0] CL = `FSR_OPC_STAT_CLEAR;
   localparam logic [7:0] PG = `FSR_OPC_PROGRAM;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic sck, cs_n, si, so, so_oe, ps, es, bs;
   logic wg_n = 1'b1, gvol = 1'b1, gfrz = 1'b0;
   logic tgt = 1'b0, otp = 1'b0, afail = 1'b0;
   logic [7:0] stat;
   logic [7:0] rd2;
   fsr_op_t kind;
   logic [7:0] np = 8'h00, ne = 8'h00, nb = 8'h00;
   int bad_count = 0;
   int tests_run = 0;
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      np <= np + {7'h00, ps};
      ne <= ne + {7'h00, es};
      nb <= nb + {7'h00, bs};
   end
   fsr_status_reg #(.NV_WRITE_CYCLES(20), .PROG_CYCLES(30),
         .ERASE_CYCLES(200), .BULK_CYCLES(50)) dut (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sck_i(sck),
      .cs_n_i(cs_n), .si_i(si), .write_guard_n_i(wg_n),
      .guard_volatile_i(gvol), .guard_freeze_i(gfrz),
      .target_guarded_i(tgt), .otp_locked_i(otp),
      .array_fail_i(afail), .so_o(so), .so_oe_o(so_oe),
      .status_byte_one_o(stat), .op_kind_o(kind),
      .program_start_o(ps), .erase_start_o(es), .bulk_start_o(bs));
   fsr_host_model host (.clock_i(clock_i), .so_i(so), .so_oe_i(so_oe),
      .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
   // --------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
         input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] op, input logic [7:0] d = 8'h00,
         input int n = 1);
      logic [7:0] rd;
      host.xfer(op, d, n, rd);
   endtask : cmd
   task automatic rd_chk(input logic [7:0] e);
      logic [7:0] rd;
      host.xfer(`FSR_OPC_STAT_READ, 8'h00, 2, rd);
      chk("status read", e, rd);
      chk("status port", e, stat);
   endtask : rd_chk
   task automatic wr(input logic pin, input logic [7:0] d,
         input logic [7:0] e);
      @(posedge clock_i) wg_n <= pin;
      cmd(WS);
      cmd(`FSR_OPC_REG_WRITE, d, 2);
      rd_chk(e);
      cmd(WC);
   endtask : wr
   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   // --------------------------------------------------------------
   // sequences
   // --------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      rd_chk(8'h1C);
      cmd(`FSR_OPC_REG_WRITE, 8'h80, 2);
      cmd(PG);
      rd_chk(8'h1C);
      cmd(WS);
      rd_chk(8'h1E);
      wr(1'b1, 8'h83, 8'h80);
      wr(1'b0, 8'h00, 8'h82);
      wr(1'b1, 8'h00, 8'h00);
      wr(1'b0, 8'h9C, 8'h9C);
      note("register write");
      cmd(WS);
      cmd(`FSR_OPC_BULK_ERASE);
      rd_chk(8'h9E);
      tgt <= 1'b1;
      cmd(`FSR_OPC_SECT_ERASE);
      rd_chk(8'hBF);
      cmd(WC);
      rd_chk(8'hBF);
      cmd(CL);
      rd_chk(8'h9E);
      cmd(WC);
      rd_chk(8'h9C);
      chk("erase starts", 8'h00, ne);
      wr(1'b1, 8'h00, 8'h00);
      note("erase fail");
      tgt <= 1'b0;
      otp <= 1'b1;
      cmd(WS);
      cmd(PG);
      rd_chk(8'h43);
      otp <= 1'b0;
      afail <= 1'b1;
      cmd(CL);
      cmd(WS);
      cmd(PG);
      rd_chk(8'h43);
      afail <= 1'b0;
      cmd(CL);
      cmd(WC);
      rd_chk(8'h00);
      cmd(WS);
      cmd(PG);
      #1 chk("busy", 8'h01, {7'h00, stat[0]});
      chk("op kind", {5'h00, FSR_OP_PROG}, {5'h00, kind});
      rd_chk(8'h00);
      chk("program starts", 8'h02, np);
      note("program");
      tgt <= 1'b1;
      cmd(WS);
      cmd(`FSR_OPC_BULK_ERASE);
      rd_chk(8'h00);
      chk("bulk starts", 8'h01, nb);
      note("bulk erase");
      tgt <= 1'b0;
      cmd(WS);
      cmd(`FSR_OPC_SECT_ERASE);
      cmd(`FSR_OPC_ERASE_PAUSE);
      rd_chk(8'h02);
      host.xfer(`FSR_OPC_STAT2_READ, 8'h00, 2, rd2);
      chk("status two", `FSR_STAT2_VALUE, rd2);
      cmd(`FSR_OPC_ERASE_RESUME);
      rd_chk(8'h00);
      chk("erase starts", 8'h01, ne);
      note("erase pause");
      cmd(WS);
      cmd(`FSR_OPC_SW_RESET);
      rd_chk(8'h1C);
      gvol <= 1'b0;
      wr(1'b1, 8'h08, 8'h08);
      gvol <= 1'b1;
      rd_chk(8'h1C);
      gfrz <= 1'b1;
      wr(1'b1, 8'h00, 8'h1C);
      note("reset and freeze");
      summarize();
   end
   initial begin
      #900_000;
      bad_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      summarize();
   end
endmodule : fsr_status_reg_tb_top
`default_nettype wire
